/* File: verilog/ddp_pkg.sv */
package ddp_pkg;
    // memory type select
    localparam logic MODE_EDO = 1'b0;
    localparam logic MODE_SDR = 1'b1;
    // sdram command codes {ras_n, cas_n, we_n}
    localparam logic [2:0] SDR_NOP = 3'h7;
    localparam logic [2:0] SDR_ACTIVE = 3'h3;
    localparam logic [2:0] SDR_READ = 3'h5;
    localparam logic [2:0] SDR_WRITE = 3'h4;
    localparam logic [2:0] SDR_PRECHARGE = 3'h2;
    localparam logic [2:0] SDR_REFRESH = 3'h1;
    localparam logic [2:0] SDR_LOAD_MODE = 3'h0;
    // address field layout
    localparam int ADDR_W = 11;
    localparam int COL_W = 8;
    localparam int AP_BIT = 10;
    localparam int MODE_BA_BIT = 11;
    localparam int MODE_W = 12;
    localparam int DATA_W = 16;
    localparam int LANES = 2;
    // capacity codes: 0.5, 1, 2, 4 megabytes
    localparam logic [1:0] CAP_512K = 2'h0;
    localparam logic [1:0] CAP_1M = 2'h1;
    localparam logic [1:0] CAP_2M = 2'h2;
    localparam logic [1:0] CAP_4M = 2'h3;
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam logic [1:0] STROBE_RST = 2'h3;
    // user command requests
    typedef enum logic [2:0] {
        DDP_REQ_NONE,
        DDP_REQ_ACTIVE,
        DDP_REQ_READ,
        DDP_REQ_WRITE,
        DDP_REQ_PRECHARGE,
        DDP_REQ_REFRESH,
        DDP_REQ_LOAD_MODE,
        DDP_REQ_SELF_REFRESH
    } ddp_req_t;
endpackage

/* File: verilog/ddp_clk_fwd.sv */
`timescale 1ns/1ps
// forwarded memory clock, gated by clock enable
module ddp_clk_fwd
    import ddp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_run,
    output logic o_clk
);
    // R13 clock gated by enable
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_clk <= 1'b0;
        end else if (i_run) begin
            o_clk <= ~o_clk;
        end else begin
            o_clk <= 1'b0;
        end
    end
endmodule

/* File: verilog/ddp_pins.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: ACTIVE drives the full row address on all eleven address lines; the code clears row bits 10:9 for 512K parts and bit 10 for 1M parts.
// R2: READ/WRITE put column on bits 7:0, bit 10 asks auto precharge.
// R3: PRECHARGE drives bit 10 high for all banks, low for one.
// R4: bank select names the bank of ACTIVE, READ, WRITE, PRECHARGE.
// R5: mode register load puts value bit 12 on bank select; the code drives value bit 11 (MODE_BA_BIT).
// R6: row strobes are EDO row strobes or SDRAM chip selects, active low.
// R7: column strobes are EDO column strobes or SDRAM byte masks.
// R8: mask blocks write byte, disables read byte; mask0 low byte.
// R9: shared enable pin is EDO read enable or SDRAM clock enable.
// R10: clock enable high to run; low with NOP gives power-down.
// R11: SDRAM commands encoded on row, column, write strobes and select.
// R12: write pin is EDO write strobe or SDRAM command input.
// R13: clock enable gates forwarded clock; clock idle in EDO mode.
// R14: sixteen-bit data path with 0.5, 1, 2 or 4 megabyte sizes.
// R15: supports both SDRAM and one-cycle EDO memory.
// R16: controller can put SDRAM into self refresh.
// R17: static mode input selects meaning; unused pins held inactive.
module ddp_pins
    import ddp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_mode_sdr,
    input wire logic [1:0] i_capacity,
    input wire logic i_req_valid,
    input wire ddp_req_t i_req,
    input wire logic i_req_chip,
    input wire logic i_req_bank,
    input wire logic [ADDR_W-1:0] i_req_row,
    input wire logic [COL_W-1:0] i_req_col,
    input wire logic i_req_auto_pre,
    input wire logic i_req_all_banks,
    input wire logic [MODE_W-1:0] i_req_mode_val,
    input wire logic [LANES-1:0] i_req_byte_en,
    input wire logic i_power_down,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic [DATA_W-1:0] i_mem_data_in,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_bank_sel,
    output logic [1:0] o_row_strobe_n,
    output logic [1:0] o_col_strobe_n,
    output logic o_oe_cke,
    output logic o_we_n,
    output logic o_cmd_row_strobe_n,
    output logic o_cmd_col_strobe_n,
    output logic o_mem_clock_out,
    output logic [DATA_W-1:0] o_mem_data_out,
    output logic [DATA_W-1:0] o_mem_data_oe,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_self_refresh
);
    logic [2:0] cmd_d;
    logic [ADDR_W-1:0] addr_d;
    logic ba_d;
    logic [1:0] cs_n_d;
    logic [1:0] mask_d;
    logic cke_d;
    logic cke_q;
    logic self_ref_q;
    logic rd_pend_q;
    logic wr_now;
    logic [ADDR_W-1:0] row_masked;

    // R14 unused upper row bits cleared for small parts
    always_comb begin
        row_masked = i_req_row;
        if (i_capacity == CAP_512K) begin
            row_masked[AP_BIT:AP_BIT-1] = 2'h0;
        end else if (i_capacity == CAP_1M) begin
            row_masked[AP_BIT] = 1'b0;
        end
    end

    // R11 command truth table, R1..R5 address and bank
    always_comb begin
        cmd_d = SDR_NOP;
        addr_d = ADDR_RST;
        ba_d = 1'b0;
        wr_now = 1'b0;
        if (i_req_valid) begin
            ba_d = i_req_bank;
            case (i_req)
                // R1 full row address
                DDP_REQ_ACTIVE: begin
                    cmd_d = SDR_ACTIVE;
                    addr_d = row_masked;
                end
                // R2 column, auto precharge
                DDP_REQ_READ: begin
                    cmd_d = SDR_READ;
                    addr_d[COL_W-1:0] = i_req_col;
                    addr_d[AP_BIT] = i_req_auto_pre;
                end
                DDP_REQ_WRITE: begin
                    cmd_d = SDR_WRITE;
                    addr_d[COL_W-1:0] = i_req_col;
                    addr_d[AP_BIT] = i_req_auto_pre;
                    wr_now = 1'b1;
                end
                // R3 all-bank line
                DDP_REQ_PRECHARGE: begin
                    cmd_d = SDR_PRECHARGE;
                    addr_d[AP_BIT] = i_req_all_banks;
                end
                DDP_REQ_REFRESH, DDP_REQ_SELF_REFRESH: begin
                    cmd_d = SDR_REFRESH;
                end
                DDP_REQ_LOAD_MODE: begin
                    cmd_d = SDR_LOAD_MODE;
                    addr_d = i_req_mode_val[ADDR_W-1:0];
                    ba_d = i_req_mode_val[MODE_BA_BIT];
                end
                default: begin
                    cmd_d = SDR_NOP;
                end
            endcase
        end
    end

    // R6 one chip select per request
    always_comb begin
        cs_n_d = STROBE_RST;
        if (i_req_valid && i_req != DDP_REQ_NONE) begin
            cs_n_d[i_req_chip] = 1'b0;
        end
        // R8 masks high block lanes
        mask_d = ~i_req_byte_en;
    end

    // R10 R16 clock enable drops for power-down or self refresh
    always_comb begin
        cke_d = ~i_power_down & ~self_ref_q;
        if (i_req_valid && i_req == DDP_REQ_SELF_REFRESH) begin
            cke_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            self_ref_q <= 1'b0;
        end else if (i_mode_sdr && i_req_valid &&
                     i_req == DDP_REQ_SELF_REFRESH) begin
            // R16 enter self refresh
            self_ref_q <= 1'b1;
        end else if (!i_power_down) begin
            self_ref_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= i_mode_sdr & cke_d;
        end
    end

    // R17 R15 pins per mode; unused ones held inactive
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_mem_addr <= ADDR_RST;
            o_bank_sel <= 1'b0;
            o_row_strobe_n <= STROBE_RST;
            o_col_strobe_n <= STROBE_RST;
            o_oe_cke <= 1'b1;
            o_we_n <= 1'b1;
            o_cmd_row_strobe_n <= 1'b1;
            o_cmd_col_strobe_n <= 1'b1;
        end else if (i_mode_sdr) begin
            o_mem_addr <= addr_d;
            // R4 R5 bank select
            o_bank_sel <= ba_d;
            // R6 chip selects
            o_row_strobe_n <= cs_n_d;
            // R7 R8 byte masks
            o_col_strobe_n <= mask_d;
            // R9 clock enable
            o_oe_cke <= cke_d;
            // R11 R12 command pins
            o_cmd_row_strobe_n <= cmd_d[2];
            o_cmd_col_strobe_n <= cmd_d[1];
            o_we_n <= cmd_d[0];
        end else begin
            // EDO one-cycle access: strobes follow request
            o_bank_sel <= 1'b0;
            o_cmd_row_strobe_n <= 1'b1;
            o_cmd_col_strobe_n <= 1'b1;
            o_mem_addr <= (i_req == DDP_REQ_ACTIVE) ? row_masked
                          : {3'h0, i_req_col};
            o_row_strobe_n <= cs_n_d;
            o_col_strobe_n <= (i_req_valid && (i_req == DDP_REQ_READ ||
                               i_req == DDP_REQ_WRITE)) ? mask_d
                              : STROBE_RST;
            // R9 EDO read output enable
            o_oe_cke <= ~(i_req_valid && i_req == DDP_REQ_READ);
            // R12 EDO write strobe
            o_we_n <= ~wr_now;
        end
    end

    // data bus drive per byte lane
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_mem_data_out <= 16'h0000;
            o_mem_data_oe <= 16'h0000;
            rd_pend_q <= 1'b0;
            o_rd_data <= 16'h0000;
        end else begin
            o_mem_data_out <= i_wr_data;
            o_mem_data_oe <= {{8{wr_now & i_req_byte_en[1]}},
                              {8{wr_now & i_req_byte_en[0]}}};
            rd_pend_q <= i_req_valid && i_req == DDP_REQ_READ;
            if (rd_pend_q) begin
                o_rd_data <= i_mem_data_in;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_self_refresh <= 1'b0;
        end else begin
            o_self_refresh <= self_ref_q;
        end
    end

    // R13 forwarded clock runs only with clock enable in SDRAM mode
    ddp_clk_fwd u_clk (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_run(cke_q),
        .o_clk(o_mem_clock_out)
    );

    property p_precharge_all;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_mode_sdr && i_req_valid && i_req == DDP_REQ_PRECHARGE)
        |=> (o_mem_addr[AP_BIT] == $past(i_req_all_banks));
    endproperty
    a_precharge_all: assert property (p_precharge_all) // R3
        else $error("precharge bank line wrong");

    property p_load_mode_ba;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_mode_sdr && i_req_valid && i_req == DDP_REQ_LOAD_MODE)
        |=> (o_bank_sel == $past(i_req_mode_val[MODE_BA_BIT]))
            && !o_cmd_row_strobe_n && !o_we_n;
    endproperty
    a_load_mode_ba: assert property (p_load_mode_ba) // R5
        else $error("mode load bank bit wrong");

    property p_edo_quiet;
        @(posedge i_ref_clk) disable iff (i_reset)
        !i_mode_sdr ##1 !i_mode_sdr |-> o_cmd_row_strobe_n
            && o_cmd_col_strobe_n && !o_bank_sel;
    endproperty
    a_edo_quiet: assert property (p_edo_quiet) // R17
        else $error("unused pins active in EDO mode");

    // row bits below the capacity trim must always pass through
    sequence s_sdr_active;
        i_mode_sdr && i_req_valid && i_req == DDP_REQ_ACTIVE;
    endsequence
    sequence s_active_pins;
        !o_cmd_row_strobe_n && o_cmd_col_strobe_n && o_we_n;
    endsequence
    property p_active_row;
        @(posedge i_ref_clk) disable iff (i_reset)
        s_sdr_active |=> s_active_pins
            ##0 (o_mem_addr[AP_BIT-2:0] == $past(i_req_row[AP_BIT-2:0]));
    endproperty
    a_active_row: assert property (p_active_row) // R1
        else $error("active row address wrong");

    property p_one_chip;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_req_valid && i_req != DDP_REQ_NONE)
        |=> (o_row_strobe_n == ($past(i_req_chip) ? 2'h1 : 2'h2));
    endproperty
    a_one_chip: assert property (p_one_chip) // R6
        else $error("chip select not one-hot");

    property p_power_down;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_mode_sdr && i_power_down) |=> !o_oe_cke;
    endproperty
    a_power_down: assert property (p_power_down) // R10
        else $error("clock enable high in power-down");

    property p_clk_gated;
        @(posedge i_ref_clk) disable iff (i_reset)
        !cke_q |=> !o_mem_clock_out;
    endproperty
    a_clk_gated: assert property (p_clk_gated) // R13
        else $error("memory clock runs without enable");
endmodule

/* File: verif/ddp_mem_model.sv */
`timescale 1ns/1ps
// memory chip stand-in: answers selected reads on the data bus
module ddp_mem_model
    import ddp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [ADDR_W-1:0] i_mem_addr,
    input wire logic [1:0] i_cs_n,
    input wire logic i_cke,
    input wire logic [2:0] i_cmd,
    output logic [DATA_W-1:0] o_data
);
    logic [DATA_W-1:0] last_q = '0;
    // sdram read needs clock enable; edo read has enable low
    // released bus toggles so a stale value never looks valid
    assign o_data = ((i_cke && i_cs_n != 2'h3 && i_cmd == SDR_READ) ||
        (!i_cke && i_cs_n != 2'h3 && i_cmd == SDR_NOP)) ?
        {8'h5A, i_mem_addr[7:0]} : ~last_q;
    always_ff @(posedge i_ref_clk) begin
        last_q <= o_data;
    end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import ddp_pkg::*;
    logic clk = 0, rst = 1, mode = 1, val = 0, chip = 0, bank = 0;
    logic ap = 0, all = 0, pd = 0, pv = 0, prd = 0, prd2 = 0, a, pw = 0;
    ddp_req_t req = DDP_REQ_NONE;
    logic [1:0] ben = 2'h3, rs, cs;
    logic [1:0] cap = CAP_4M;
    logic [10:0] row = '0, addr;
    logic [7:0] col = '0;
    logic [11:0] mv = '0;
    logic [15:0] wd = '0, mdi, rdd, mdo, mdoe;
    logic ba, oe, we, cr, cc, mclk, sref;
    logic [18:0] eq[$], cq[$], e, m, ce, cm;
    logic [15:0] rq[$];
    logic [31:0] wq[$];
    logic [2:0] code [8] = '{SDR_NOP, SDR_ACTIVE, SDR_READ, SDR_WRITE,
        SDR_PRECHARGE, SDR_REFRESH, SDR_LOAD_MODE, SDR_REFRESH};
    logic [31:0] lfsr = 32'h9C2656E9;
    int n_mismatch = 0, checks_done = 0;
    always #20 clk = ~clk;
    ddp_pins i_ddp_pins(.i_ref_clk(clk), .i_reset(rst), .i_mode_sdr(mode),
        .i_capacity(cap), .i_req_valid(val), .i_req(req),
        .i_req_chip(chip), .i_req_bank(bank), .i_req_row(row),
        .i_req_col(col), .i_req_auto_pre(ap), .i_req_all_banks(all),
        .i_req_mode_val(mv), .i_req_byte_en(ben), .i_power_down(pd),
        .i_wr_data(wd), .i_mem_data_in(mdi), .o_mem_addr(addr),
        .o_bank_sel(ba), .o_row_strobe_n(rs), .o_col_strobe_n(cs),
        .o_oe_cke(oe), .o_we_n(we), .o_cmd_row_strobe_n(cr),
        .o_cmd_col_strobe_n(cc), .o_mem_clock_out(mclk),
        .o_mem_data_out(mdo), .o_mem_data_oe(mdoe), .o_rd_data(rdd),
        .o_self_refresh(sref));
    ddp_mem_model i_ddp_mem_model(.i_ref_clk(clk), .i_mem_addr(addr),
        .i_cs_n(rs), .i_cke(oe), .i_cmd({cr, cc, we}), .o_data(mdi));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic idle(input int n);
        @(posedge clk);
        val <= 0;
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input ddp_req_t r, input logic c);
        logic [31:0] x;
        logic [2:0] k;
        logic [1:0] s;
        logic [10:0] rw;
        x = rnd();
        k = code[r];
        s = c ? 2'h1 : 2'h2;
        // small parts leave the top row lines low
        rw = x[11:1];
        if (x[25:24] == CAP_512K) rw[10:9] = 2'h0;
        else if (x[25:24] == CAP_1M) rw[10] = 1'b0;
        @(posedge clk);
        val <= 1; req <= r; chip <= c; bank <= x[0]; row <= x[11:1];
        col <= x[19:12]; ap <= x[20]; all <= x[21]; mv <= x[31:20];
        ben <= x[23:22]; wd <= x[15:0];
        cap <= x[25:24];
        if (mode) begin
            case (r)
                DDP_REQ_ACTIVE: begin
                    e = {rw, x[0], s, k, 2'h0}; m = 19'h7FFFC; end
                DDP_REQ_READ, DDP_REQ_WRITE: begin
                    e = {x[20], 2'h0, x[19:12], x[0], s, k, ~x[23:22]};
                    m = 19'h4FFFF; end
                DDP_REQ_PRECHARGE: begin
                    e = {x[21], 10'h0, x[0], s, k, 2'h0}; m = 19'h400FC; end
                DDP_REQ_LOAD_MODE: begin
                    e = {x[30:20], x[31], 2'h0, k, 2'h0}; m = 19'h7FF9C; end
                default: begin e = {14'h0, k, 2'h0}; m = 19'h1C; end
            endcase
        end else if (r == DDP_REQ_ACTIVE) begin
            e = {rw, 1'b0, s, 3'h7, 2'h3};
            m = 19'h7FFFF;
        end else begin
            e = {3'h0, x[19:12], 1'b0, s, 2'h3, r != DDP_REQ_WRITE, ~x[23:22]};
            m = 19'h7FFFF;
        end
        eq.push_back(e);
        cq.push_back(m);
        if (r == DDP_REQ_READ) rq.push_back({8'h5A, x[19:12]});
        if (r == DDP_REQ_WRITE)
            wq.push_back({{8{x[23]}}, {8{x[22]}}, x[15:0]});
    endtask
    always @(posedge clk) begin
        pv <= val;
        prd <= val && req == DDP_REQ_READ;
        prd2 <= prd;
        pw <= val && req == DDP_REQ_WRITE;
    end
    always @(negedge clk) begin
        if (pv) begin
            cm = cq.pop_front();
            ce = eq.pop_front();
            chk({addr, ba, rs, cr, cc, we, cs} & cm, ce & cm);
        end
        if (prd2) chk(rdd, rq.pop_front());
        // write lanes driven only where enabled
        if (pw) chk({mdoe, mdo}, wq.pop_front());
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 14; i++) send(ddp_req_t'(1 + i % 6), i[1]);
        idle(3);
        $display("sdram commands done");
        pd <= 1;
        idle(3);
        @(negedge clk);
        chk({oe, mclk}, 0);
        send(DDP_REQ_SELF_REFRESH, 0);
        idle(2);
        @(negedge clk);
        chk(sref, 1);
        @(posedge clk);
        pd <= 0;
        idle(3);
        @(negedge clk);
        a = mclk;
        @(negedge clk);
        chk({oe, sref, mclk ^ a}, 3'h5);
        $display("power down and self refresh done");
        @(posedge clk);
        rst <= 1;
        mode <= 0;
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 6; i++) send(ddp_req_t'(1 + i % 3), i[0]);
        idle(2);
        @(negedge clk);
        chk({mclk, cr, cc}, 3'h3);
        $display("edo mode done");
        wrap_up();
    end
endmodule
